/* ptm_sys_time.sv */
// ptm_sys_time.sv - system time registers behind an AHB-Lite slave
// assumes: single AHB-Lite master, word transfers only, rollover pulse from
// the rate accumulator arrives synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
`include "ptm_map.svh"

// Overview of operation
// - time shown as four 16-bit words
// - loadable up-counter holding current local time
// - increment by one only on rollover
// - low word read latches upper 48 bits
// - upper word reads return the latch
// - stage low words, top write loads all
module ptm_sys_time (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire ptm_pkg::ptm_bus_t hwdata,
  output ptm_pkg::ptm_bus_t      hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              acc_rollover,
  output logic [63:0]            local_time
);
  import ptm_pkg::*;

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function automatic logic idx_is(input ptm_idx_t idx, input ptm_idx_t want);
    idx_is = (idx == want);
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  ptm_state_e  state_r;
  ptm_state_e  state_nxt;
  logic        dp_wr_r;
  ptm_idx_t    dp_idx_r;
  ptm_bus_t    hrdata_r;
  ptm_hword_t  stage_r [3];
  ptm_hword_t  tgt0_r;
  ptm_hword_t  tgt1_r;
  logic [63:0] time_w;
  logic [47:0] snap_w;

  // --------------------------------------------------------------------------
  // address phase and data phase decode
  // --------------------------------------------------------------------------
  wire       accept   = hsel & htrans[1] & hready;
  wire       acc_rd   = accept & ~hwrite;
  wire       acc_wr   = accept & hwrite;
  wire [5:0] a_idx    = haddr[`PTM_ADDR_MSB:`PTM_ADDR_LSB];
  wire       wr_en    = dp_wr_r;
  wire       wr_t0    = wr_en & idx_is(dp_idx_r, `PTM_IDX_TIME0);
  wire       wr_t1    = wr_en & idx_is(dp_idx_r, `PTM_IDX_TIME1);
  wire       wr_t2    = wr_en & idx_is(dp_idx_r, `PTM_IDX_TIME2);
  wire       wr_t3    = wr_en & idx_is(dp_idx_r, `PTM_IDX_TIME3);
  wire       wr_g0    = wr_en & idx_is(dp_idx_r, `PTM_IDX_TGT0);
  wire       wr_g1    = wr_en & idx_is(dp_idx_r, `PTM_IDX_TGT1);
  wire       rd_cap   = (state_r == PTM_ST_RDWAIT);
  wire       rd_snap  = rd_cap & idx_is(dp_idx_r, `PTM_IDX_TIME0);
  wire [2:0] stage_we = {wr_t2, wr_t1, wr_t0};
  wire [63:0] load_val = {hwdata[15:0], stage_r[2], stage_r[1], stage_r[0]};

  // read mux: low word live, upper words from the latch, unmapped reads zero
  wire [15:0] rd_word =
    idx_is(dp_idx_r, `PTM_IDX_TIME0) ? time_w[15:0]  :
    idx_is(dp_idx_r, `PTM_IDX_TIME1) ? snap_w[15:0]  :
    idx_is(dp_idx_r, `PTM_IDX_TIME2) ? snap_w[31:16] :
    idx_is(dp_idx_r, `PTM_IDX_TIME3) ? snap_w[47:32] :
    idx_is(dp_idx_r, `PTM_IDX_TGT0)  ? tgt0_r        :
    idx_is(dp_idx_r, `PTM_IDX_TGT1)  ? tgt1_r        :
    `PTM_RST_WORD;

  // --------------------------------------------------------------------------
  // bus slave state machine: reads take one wait state, writes none
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PTM_ST_IDLE:   state_nxt = acc_rd ? PTM_ST_RDWAIT : PTM_ST_IDLE;
      PTM_ST_RDWAIT: state_nxt = PTM_ST_RDOUT;
      PTM_ST_RDOUT:  state_nxt = acc_rd ? PTM_ST_RDWAIT : PTM_ST_IDLE;
      default:       state_nxt = PTM_ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= PTM_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // data phase capture of the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r  <= 1'b0;
      dp_idx_r <= '0;
    end else if (hready) begin
      dp_wr_r  <= acc_wr;
      dp_idx_r <= accept ? a_idx : dp_idx_r;
    end
  end

  // read data registered at the end of the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (rd_cap) begin
      hrdata_r <= {16'h0000, rd_word};
    end
  end

  // --------------------------------------------------------------------------
  // staging words for the three low time words
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_stage
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stage_r[i] <= `PTM_RST_WORD;
      end else if (stage_we[i]) begin
        stage_r[i] <= hwdata[15:0];
      end
    end
  end

  // first target time, low two words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt0_r <= `PTM_RST_WORD;
      tgt1_r <= `PTM_RST_WORD;
    end else begin
      if (wr_g0) begin
        tgt0_r <= hwdata[15:0];
      end
      if (wr_g1) begin
        tgt1_r <= hwdata[15:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // counter and snapshot latch
  // --------------------------------------------------------------------------
  ptm_time_core #(
    .TIME_W (64),
    .SNAP_W (48)
  ) u_core (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .inc      (acc_rollover),
    .load     (wr_t3),
    .load_val (load_val),
    .snap     (rd_snap),
    .time_o   (time_w),
    .snap_o   (snap_w)
  );

  // outputs
  assign hrdata     = hrdata_r;
  assign hreadyout  = (state_r != PTM_ST_RDWAIT);
  assign hresp      = 1'b0;
  assign local_time = time_w;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_inc_one;
    (acc_rollover && !wr_t3) |=> (time_w == $past(time_w) + `PTM_TIME_INC);
  endproperty
  a_inc_one: assert property (p_inc_one) else $error("time did not step by one");

  property p_no_drift;
    (!acc_rollover && !wr_t3) |=> $stable(time_w);
  endproperty
  a_no_drift: assert property (p_no_drift) else $error("time moved without rollover");

  property p_load_all;
    wr_t3 |=> (time_w == {$past(hwdata[15:0]), $past(stage_r[2]),
                          $past(stage_r[1]), $past(stage_r[0])});
  endproperty
  a_load_all: assert property (p_load_all) else $error("64-bit load wrong");

  property p_stage_no_load;
    (wr_t0 || wr_t1 || wr_t2) && !acc_rollover |=> $stable(time_w);
  endproperty
  a_stage_no_load: assert property (p_stage_no_load) else $error("low write moved time");

  sequence s_rd_low;
    rd_snap;
  endsequence
  sequence s_out_upper;
    (state_r == PTM_ST_RDOUT) && (hrdata[15:0] == snap_w[15:0]);
  endsequence

  property p_snap;
    s_rd_low |=> (snap_w == $past(time_w[63:16]));
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot not taken");

  property p_upper_from_latch;
    (rd_cap && idx_is(dp_idx_r, `PTM_IDX_TIME1) && !rd_snap) |=> s_out_upper;
  endproperty
  a_upper_from_latch: assert property (p_upper_from_latch) else $error("upper read not latched");

  property p_read_wait;
    acc_rd |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

  property p_word_narrow;
    (state_r == PTM_ST_RDOUT) |-> (hrdata[31:16] == 16'h0000);
  endproperty
  a_word_narrow: assert property (p_word_narrow) else $error("upper bus bits not zero");

  property p_tgt_write;
    wr_g0 |=> (tgt0_r == $past(hwdata[15:0]));
  endproperty
  a_tgt_write: assert property (p_tgt_write) else $error("target word 0 not stored");

endmodule
`default_nettype wire

/* ptm_map.svh */
// ptm_map.svh - offsets, reset values and field positions of the system time block
// assumes: included by bare name from the package and the design files
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define PTM_IDX_TIME0   6'h0C
`define PTM_IDX_TIME1   6'h0E
`define PTM_IDX_TIME2   6'h10
`define PTM_IDX_TIME3   6'h12
`define PTM_IDX_TGT0    6'h14
`define PTM_IDX_TGT1    6'h16

// ----------------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------------
`define PTM_WORD_W      16
`define PTM_ADDR_LSB    2
`define PTM_ADDR_MSB    7
`define PTM_RST_WORD    16'h0000
`define PTM_RST_TIME    64'h0000_0000_0000_0000
`define PTM_TIME_INC    64'h0000_0000_0000_0001

`endif

/* ptm_pkg.sv */
// ptm_pkg.sv - types shared by the system time block
// assumes: ptm_map.svh is on the include path
`default_nettype none
`include "ptm_map.svh"

package ptm_pkg;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef logic [31:0]              ptm_bus_t;
  typedef logic [`PTM_WORD_W-1:0]   ptm_hword_t;
  typedef logic [5:0]               ptm_idx_t;

  // bus slave states, gray along idle -> wait -> out
  typedef enum logic [1:0] {
    PTM_ST_IDLE   = 2'b00,
    PTM_ST_RDWAIT = 2'b01,
    PTM_ST_RDOUT  = 2'b11
  } ptm_state_e;

endpackage
`default_nettype wire

/* ptm_time_core.sv */
// ptm_time_core.sv - loadable 64-bit up-counter with upper-word snapshot latch
// assumes: one clock, asynchronous active-low reset, pulses one cycle wide
`timescale 1ns/1ps
`default_nettype none
`include "ptm_map.svh"

module ptm_time_core #(
  parameter int TIME_W = 64,
  parameter int SNAP_W = 48
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              inc,
  input  wire logic              load,
  input  wire logic [TIME_W-1:0] load_val,
  input  wire logic              snap,
  output logic      [TIME_W-1:0] time_o,
  output logic      [SNAP_W-1:0] snap_o
);

  // --------------------------------------------------------------------------
  // elaboration check
  // --------------------------------------------------------------------------
  if (TIME_W != 64 || SNAP_W != TIME_W - 16) begin : g_bad_width
    $error("ptm_time_core: widths must be 64 and 48");
  end

  logic [TIME_W-1:0] time_r;
  logic [SNAP_W-1:0] snap_r;

  // load beats increment; apart from a load the counter moves only on rollover
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_r <= `PTM_RST_TIME;
    end else if (load) begin
      time_r <= load_val;
    end else if (inc) begin
      time_r <= time_r + `PTM_TIME_INC;
    end
  end

  // upper 48 bits caught when the low word is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_r <= '0;
    end else if (snap) begin
      snap_r <= time_r[TIME_W-1:TIME_W-SNAP_W];
    end
  end

  assign time_o = time_r;
  assign snap_o = snap_r;

endmodule
`default_nettype wire

/* ptm_sys_time_tb_top.sv */
// ptm_sys_time_tb_top.sv - self-checking bench for the system time block
// assumes: ptm_map.svh on the include path, ptm_pkg compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ptm_map.svh"

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module ptm_sys_time_tb_top;
  import ptm_pkg::*;

  // ---------------------------------------------------------------------------
  // signals and counters
  // ---------------------------------------------------------------------------
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        acc_rollover = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  ptm_bus_t    hwdata = 32'h0;
  ptm_bus_t    hrdata;
  ptm_bus_t    rd;
  logic        hreadyout;
  logic        hresp;
  logic [63:0] local_time;
  logic [63:0] t;
  logic [63:0] exp_t;
  logic [63:0] snap;
  logic [15:0] tg;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed = 59941;
  int          n;

  // 25 MHz clock
  always #20 hclk = ~hclk;

  ptm_sys_time dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .acc_rollover(acc_rollover), .local_time(local_time)
  );

  // ---------------------------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------------------------
  // byte address of word i: time0..3, then the two target words
  function automatic logic [7:0] ra(input int i);
    logic [5:0] x [6] = '{`PTM_IDX_TIME0, `PTM_IDX_TIME1, `PTM_IDX_TIME2,
                          `PTM_IDX_TIME3, `PTM_IDX_TGT0, `PTM_IDX_TGT1};
    return {x[i], 2'b00};
  endfunction

  // 16-bit word i of a 64-bit time, zero-extended as the bus returns it
  function automatic ptm_bus_t word(input logic [63:0] v, input int i);
    return {16'h0000, v[16*i +: 16]};
  endfunction

  // ---------------------------------------------------------------------------
  // bus master tasks, entered and left just after a rising edge
  // ---------------------------------------------------------------------------
  task automatic addr_phase(input logic [7:0] a, input logic w);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    addr_phase(a, 1'b1);
    hwdata <= {$random(seed)} & 32'hFFFF0000 | {16'h0000, d};  // junk in unused upper half
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic bus_rd(input logic [7:0] a, output ptm_bus_t d);
    addr_phase(a, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  // hold the rollover pulse high for k edges, then let one quiet edge pass
  task automatic roll(input int k);
    repeat (k) begin
      @(posedge hclk);
      acc_rollover <= 1'b1;
    end
    @(posedge hclk);
    acc_rollover <= 1'b0;
    @(posedge hclk);
  endtask

  // ---------------------------------------------------------------------------
  // verdict and hang guard
  // ---------------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // run is under a thousand cycles; forty times that means a hang
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // every register and the snapshot read zero after reset
    for (int i = 0; i < 6; i++) begin
      bus_rd(ra(i), rd);
      `CHK("reset word", 32'h0, rd)
    end
    `CHK("reset time", 64'h0, local_time)
    exp_t = 64'h0;
    $display("test reset done");
    // loads, counting, coherent reads, targets; first pass is a carry corner
    for (int k = 0; k < 8; k++) begin
      t = (k == 0) ? 64'h0000_FFFF_FFFF_FFFF : {$random(seed), $random(seed)};
      n = (k == 0) ? 1 : 1 + ({$random(seed)} % 40);
      for (int i = 0; i < 3; i++) begin
        bus_wr(ra(i), t[16*i +: 16]);
        `CHK("staged time", exp_t, local_time)
      end
      bus_wr(ra(3), t[63:48]);
      @(posedge hclk);
      exp_t = t;
      `CHK("loaded time", exp_t, local_time)
      roll(n);
      exp_t = exp_t + 64'(n);
      `CHK("counted time", exp_t, local_time)
      repeat (3) @(posedge hclk);
      `CHK("idle time", exp_t, local_time)
      bus_rd(ra(0), rd);
      `CHK("low word", word(exp_t, 0), rd)
      snap = exp_t;
      roll(n);
      exp_t = exp_t + 64'(n);
      for (int i = 1; i < 4; i++) begin
        bus_rd(ra(i), rd);
        `CHK("latched word", word(snap, i), rd)
      end
      for (int i = 4; i < 6; i++) begin
        tg = 16'($random(seed));
        bus_wr(ra(i), tg);
        bus_rd(ra(i), rd);
        `CHK("target word", {16'h0000, tg}, rd)
      end
      // unmapped place: write ignored, reads zero, time untouched
      bus_wr(8'h04, 16'hFFFF);
      bus_rd(8'h04, rd);
      `CHK("unmapped", 32'h0, rd)
      `CHK("time after unmapped", exp_t, local_time)
      $display("test load %0d done", k);
    end
    give_verdict();
  end

endmodule

`default_nettype wire
